// file: euflg_biu_model.sv
/*
  Stand-in for the bus interface unit: advances the fetch pointer while enabled.
  Assumes the execution unit state block on the same clock and reset.
*/
`timescale 1ns/1ps
module euflg_biu_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic slow,
  output logic ip_fetch_step,
  output logic [1:0] ip_step,
  output logic [7:0] n_steps
);
  logic [1:0] gap; // Idle cycles left before the next step

  // Word fetches step by two; slow mode leaves gaps like a waited bus
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ip_fetch_step <= 1'b0;
      ip_step <= 2'h0;
      gap <= 2'h0;
      n_steps <= 8'h00;
    end else if (enable && gap == 2'h0) begin
      ip_fetch_step <= 1'b1;
      ip_step <= 2'h2;
      gap <= slow ? 2'h3 : 2'h0;
      n_steps <= n_steps + 8'h01;
    end else begin
      ip_fetch_step <= 1'b0;
      // Step size is toggled when idle so nothing leans on a stale value
      ip_step <= ~ip_step;
      if (gap != 2'h0) begin
        gap <= gap - 2'h1;
      end
    end
  end
endmodule

// file: euflg_gpr_if.sv
/*
  Carrier between the top and the general register memory: one write
  port with byte enables, one registered read port and two direct views of the count and data word registers.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface euflg_gpr_if;
  logic we;               // Write strobe
  logic [2:0] waddr;      // Write register index
  logic [1:0] wbe;        // Byte enables: bit 1 high byte
  logic [15:0] wdata;     // Write data
  logic [2:0] raddr_a;    // Read port A index
  logic [15:0] rdata_a;   // Registered read data A
  logic [15:0] count_q;   // Count register, for shifts
  logic [15:0] dataw_q;   // Data word register, for port address
  modport host (output we, waddr, wbe, wdata, raddr_a, input rdata_a, count_q, dataw_q);
  modport mem (input we, waddr, wbe, wdata, raddr_a, output rdata_a, count_q, dataw_q);
endinterface

// file: euflg_gpr_mem.sv
/*
  Eight 16-bit general registers with byte-lane writes.
  Assumes the synchronised active-low reset copy from the top.
*/
`timescale 1ns/1ps
module euflg_gpr_mem
  import euflg_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  euflg_gpr_if.mem gp
);
  logic [15:0] regs [8];  // General register array

  // Byte-lane writes make the byte halves of all eight addressable
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_reg
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          regs[g] <= EUFLG_GPR_RST;
        end else if (gp.we && gp.waddr == 3'(g)) begin
          if (gp.wbe[0]) begin
            regs[g][7:0] <= gp.wdata[7:0];
          end
          if (gp.wbe[1]) begin
            regs[g][15:8] <= gp.wdata[15:8];
          end
        end
      end
    end
  endgenerate

  // Read data leave through a register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gp.rdata_a <= EUFLG_GPR_RST;
    end else begin
      gp.rdata_a <= regs[gp.raddr_a];
    end
  end

  // Dedicated views of count and data word registers
  assign gp.count_q = regs[EUFLG_R_CNT];
  assign gp.dataw_q = regs[EUFLG_R_DAT];
endmodule

// file: euflg_pkg.sv
/*
  Package for the execution unit state block: register map for the
  Avalon-MM window, flag bit positions, reset values and field widths.
  Assumes nothing of its surroundings; imported whole by the top, the register memory and the bench.
*/
package euflg_pkg;

  // Avalon word indexes of the software-visible registers
  localparam logic [3:0] EUFLG_IDX_PSW = 4'h0;
  localparam logic [3:0] EUFLG_IDX_CSB = 4'h1;
  localparam logic [3:0] EUFLG_IDX_DSB = 4'h2;
  localparam logic [3:0] EUFLG_IDX_SSB = 4'h3;
  localparam logic [3:0] EUFLG_IDX_ESB = 4'h4;
  localparam logic [3:0] EUFLG_IDX_IPR = 4'h5;  // Fetch pointer slot, hidden: reads zero
  localparam logic [3:0] EUFLG_IDX_GP0 = 4'h8;  // General registers at 8..15

  // Flag bit positions
  localparam int EUFLG_B_CF = 0;
  localparam int EUFLG_B_PF = 2;
  localparam int EUFLG_B_AF = 4;
  localparam int EUFLG_B_ZF = 6;
  localparam int EUFLG_B_SF = 7;
  localparam int EUFLG_B_TF = 8;
  localparam int EUFLG_B_IF = 9;
  localparam int EUFLG_B_DF = 10;
  localparam int EUFLG_B_OF = 11;

  // Bits that can hold flag state; reserved bits stay zero
  localparam logic [15:0] EUFLG_PSW_MASK = 16'h0fd5;

  // Reset values
  localparam logic [15:0] EUFLG_PSW_RST = 16'h0000;
  localparam logic [15:0] EUFLG_CSB_RST = 16'hffff;
  localparam logic [15:0] EUFLG_SEG_RST = 16'h0000;
  localparam logic [15:0] EUFLG_IP_RST = 16'h0000;
  localparam logic [15:0] EUFLG_GPR_RST = 16'h0000;

  // Shape of the address path
  localparam int EUFLG_SEG_SHIFT = 4;
  localparam int EUFLG_PA_W = 20;

  // Register file indexes of named general registers
  localparam logic [2:0] EUFLG_R_ACC = 3'h0;
  localparam logic [2:0] EUFLG_R_CNT = 3'h1;
  localparam logic [2:0] EUFLG_R_DAT = 3'h2;

  // Segment selectors for address generation
  typedef enum logic [1:0] {
    EUFLG_SEG_ES = 2'b00,
    EUFLG_SEG_CS = 2'b01,
    EUFLG_SEG_SS = 2'b10,
    EUFLG_SEG_DS = 2'b11
  } euflg_seg_t;

  // Bus slave states
  typedef enum logic [1:0] {
    EUFLG_BUS_IDLE = 2'b00,
    EUFLG_BUS_ANS = 2'b01,
    EUFLG_BUS_DONE = 2'b10
  } euflg_bus_t;

endpackage

// file: euflg_top.sv
/*
  Execution unit architectural state: general registers, segment bases,
  fetch offset pointer, status flags and physical address generation.
  Assumes an Avalon-MM master with waitrequest and an execution engine
  that drives one-cycle result strobes on the same clock.
*/
`timescale 1ns/1ps
module euflg_top
  import euflg_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic res_valid,
  input wire logic res_byte,
  input wire logic [15:0] res_value,
  input wire logic res_carry,
  input wire logic res_aux,
  input wire logic res_ovf,
  input wire logic instr_done,
  input wire logic flags_load,
  input wire logic [15:0] flags_value,
  input wire logic flags_popped,
  input wire logic set_direction_instr,
  input wire logic clear_direction_instr,
  input wire logic set_int_enable_instr,
  input wire logic clear_int_enable_instr,
  input wire logic ip_load,
  input wire logic [15:0] ip_value,
  input wire logic ip_fetch_step,
  input wire logic [1:0] ip_step,
  input wire logic [1:0] agen_seg,
  input wire logic [15:0] agen_offset,
  input wire logic irq_request,
  output logic [19:0] phys_addr,
  output logic [19:0] fetch_addr,
  output logic [4:0] shift_count,
  output logic [15:0] io_port_addr,
  output logic string_step_up,
  output logic irq_accept,
  output logic trace_trap
);
  logic rst_s1;            // Reset release synchroniser, stage 1
  logic rst_sync_n;        // Synchronised reset for the whole block
  euflg_gpr_if gp();       // Link to the register memory

  logic [15:0] processor_status_word;  // Flags
  logic [15:0] code_segment_base;
  logic [15:0] data_segment_base;
  logic [15:0] stack_segment_base;
  logic [15:0] extra_segment_base;
  logic [15:0] fetch_offset_pointer;   // Hidden from the bus both ways
  logic trace_arm;         // Trace was live before this instruction
  euflg_bus_t bus_state;   // Slave sequencer
  logic bus_is_gpr;        // Latched read of a general register
  logic gpr_rd_hit;        // Read aimed at the general register window
  logic psw_engine_busy;   // Engine touches the flags this cycle
  logic [15:0] next_psw;   // Flags after this cycle's events
  logic [15:0] wmask;      // Byte lanes of a bus write, as bit mask
  logic [15:0] lane_data;  // Low half of the bus write data

  // Combine a segment and offset into a wrapped 20-bit address
  function automatic logic [19:0] euflg_pa(input logic [15:0] seg, input logic [15:0] off);
    logic [19:0] sum;
    sum = {seg, 4'h0} + {4'h0, off};
    return sum;
  endfunction

  // Merge the enabled byte lanes of a write into an old value
  function automatic logic [15:0] euflg_merge(input logic [15:0] old_v,
    input logic [15:0] new_v, input logic [15:0] mask);
    return (old_v & ~mask) | (new_v & mask);
  endfunction

  // Pick one segment base by selector
  function automatic logic [15:0] euflg_seg_pick(input logic [1:0] sel, input logic [15:0] es_v,
    input logic [15:0] cs_v, input logic [15:0] ss_v, input logic [15:0] ds_v);
    logic [15:0] v;
    case (euflg_seg_t'(sel))
      EUFLG_SEG_ES: v = es_v;
      EUFLG_SEG_CS: v = cs_v;
      EUFLG_SEG_SS: v = ss_v;
      default: v = ds_v;
    endcase
    return v;
  endfunction

  // Release reset through two flops so removal is clean
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_sync_n <= rst_s1;
    end
  end

  euflg_gpr_mem u_mem (
    .clock(clock),
    .rst_n(rst_sync_n),
    .gp(gp)
  );

  // Lane mask for the low 16 bits of a write
  assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign lane_data = avs_writedata[15:0];

  // Bus writes of general registers go to the memory module; the window is
  // words 8..15 only, so unmapped words with bit 3 set never reach it
  assign gp.we = (bus_state == EUFLG_BUS_IDLE) && avs_write
                 && (avs_address[5:3] == 3'b001);
  assign gp.waddr = avs_address[2:0];
  assign gp.wbe = avs_byteenable[1:0];
  assign gp.wdata = avs_writedata[15:0];
  assign gp.raddr_a = avs_address[2:0];

  // Memory read data leave a flop, so these reads answer one cycle later
  assign gpr_rd_hit = avs_read && (avs_address[5:3] == 3'b001);

  // Engine flag events beat a bus write of the flags in the same cycle
  assign psw_engine_busy = res_valid || flags_load || set_direction_instr
                           || clear_direction_instr || set_int_enable_instr
                           || clear_int_enable_instr;

  // Slave sequencer: accept, then answer one cycle later with read data, two cycles later for a general register read
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bus_state <= EUFLG_BUS_IDLE;
      bus_is_gpr <= 1'b0;
    end else begin
      case (bus_state)
        EUFLG_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state <= EUFLG_BUS_ANS;
            bus_is_gpr <= gpr_rd_hit;
          end
        end
        EUFLG_BUS_ANS: bus_state <= EUFLG_BUS_DONE;  // Master samples low now, except for a general register read
        EUFLG_BUS_DONE: bus_state <= EUFLG_BUS_IDLE;  // Master drops request; a general register read is answered now
        default: bus_state <= EUFLG_BUS_IDLE;
      endcase
    end
  end

  // Waitrequest is low only in the answer cycle; a general register read
  // waits once more so that the memory's registered data can be copied out
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((bus_state == EUFLG_BUS_IDLE && (avs_read || avs_write)
                            && !gpr_rd_hit)
                           || (bus_state == EUFLG_BUS_ANS && bus_is_gpr));
    end
  end

  // Read data registered at the same time waitrequest drops
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (bus_state == EUFLG_BUS_IDLE && avs_read) begin
      if (avs_address[5:4] != 2'b00) begin
        avs_readdata <= 32'h0000_0000;  // Unmapped reads as zero
      end else if (avs_address[3]) begin
        avs_readdata <= 32'h0000_0000;  // Filled from memory next cycle
      end else begin
        case (avs_address[3:0])
          EUFLG_IDX_PSW: avs_readdata <= {16'h0000, processor_status_word};
          EUFLG_IDX_CSB: avs_readdata <= {16'h0000, code_segment_base};
          EUFLG_IDX_DSB: avs_readdata <= {16'h0000, data_segment_base};
          EUFLG_IDX_SSB: avs_readdata <= {16'h0000, stack_segment_base};
          EUFLG_IDX_ESB: avs_readdata <= {16'h0000, extra_segment_base};
          EUFLG_IDX_IPR: avs_readdata <= 32'h0000_0000;  // Pointer stays hidden
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end else if (bus_state == EUFLG_BUS_ANS && bus_is_gpr) begin
      avs_readdata <= {16'h0000, gp.rdata_a};
    end
  end

  // Segment bases; only the bus alters them here
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      code_segment_base <= EUFLG_CSB_RST;
      data_segment_base <= EUFLG_SEG_RST;
      stack_segment_base <= EUFLG_SEG_RST;
      extra_segment_base <= EUFLG_SEG_RST;
    end else if (bus_state == EUFLG_BUS_IDLE && avs_write && avs_address[5:3] == 3'b000) begin
      case (avs_address[3:0])
        EUFLG_IDX_CSB: code_segment_base <= euflg_merge(code_segment_base, lane_data, wmask);
        EUFLG_IDX_DSB: data_segment_base <= euflg_merge(data_segment_base, lane_data, wmask);
        EUFLG_IDX_SSB: stack_segment_base <= euflg_merge(stack_segment_base, lane_data, wmask);
        EUFLG_IDX_ESB: extra_segment_base <= euflg_merge(extra_segment_base, lane_data, wmask);
        default: code_segment_base <= code_segment_base;
      endcase
    end
  end

  // Fetch pointer moves only with execution; 16 bits wrap inside 64K
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fetch_offset_pointer <= EUFLG_IP_RST;
    end else if (ip_load) begin
      fetch_offset_pointer <= ip_value;
    end else if (ip_fetch_step) begin
      fetch_offset_pointer <= fetch_offset_pointer + {14'h0000, ip_step};
    end
  end

  // Flag update from results, dedicated instructions and loads
  always_comb begin
    next_psw = processor_status_word;
    if (flags_load) begin
      next_psw = flags_value & EUFLG_PSW_MASK;
    end else begin
      if (res_valid) begin
        next_psw[EUFLG_B_OF] = res_ovf;
        next_psw[EUFLG_B_SF] = res_byte ? res_value[7] : res_value[15];
        next_psw[EUFLG_B_ZF] = res_byte ? (res_value[7:0] == 8'h00)
                                        : (res_value == 16'h0000);
        next_psw[EUFLG_B_AF] = res_aux;
        next_psw[EUFLG_B_PF] = ~^res_value[7:0];
        next_psw[EUFLG_B_CF] = res_carry;
      end
      if (set_direction_instr) begin
        next_psw[EUFLG_B_DF] = 1'b1;
      end else if (clear_direction_instr) begin
        next_psw[EUFLG_B_DF] = 1'b0;
      end
      if (set_int_enable_instr) begin
        next_psw[EUFLG_B_IF] = 1'b1;
      end else if (clear_int_enable_instr) begin
        next_psw[EUFLG_B_IF] = 1'b0;
      end
    end
  end

  // Flags register; bus writes land only when no engine event competes
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      processor_status_word <= EUFLG_PSW_RST;
    end else if (bus_state == EUFLG_BUS_IDLE && avs_write && avs_address == 6'(EUFLG_IDX_PSW)
                 && !psw_engine_busy) begin
      processor_status_word <= ((processor_status_word & ~wmask)
                               | (avs_writedata[15:0] & wmask)) & EUFLG_PSW_MASK;
    end else begin
      processor_status_word <= next_psw & EUFLG_PSW_MASK;
    end
  end

  // Trace is armed at instruction end, so a flag pop defers by one
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      trace_arm <= 1'b0;
      trace_trap <= 1'b0;
    end else if (instr_done) begin
      trace_trap <= trace_arm && !flags_popped;
      trace_arm <= processor_status_word[EUFLG_B_TF] || (flags_load && flags_value[EUFLG_B_TF]);
    end else begin
      trace_trap <= 1'b0;
    end
  end

  // Address outputs and helper views, all registered
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phys_addr <= 20'h00000;
      fetch_addr <= 20'hffff0;
      shift_count <= 5'h00;
      io_port_addr <= 16'h0000;
      string_step_up <= 1'b0;
      irq_accept <= 1'b0;
    end else begin
      phys_addr <= euflg_pa(euflg_seg_pick(agen_seg, extra_segment_base, code_segment_base,
                   stack_segment_base, data_segment_base), agen_offset);
      fetch_addr <= euflg_pa(code_segment_base, fetch_offset_pointer);
      shift_count <= gp.count_q[4:0];
      io_port_addr <= gp.dataw_q;
      string_step_up <= processor_status_word[EUFLG_B_DF];
      irq_accept <= irq_request && processor_status_word[EUFLG_B_IF];
    end
  end

  // Reserved flag bits never hold state
  psw_rsvd_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (processor_status_word & ~EUFLG_PSW_MASK) == 16'h0000)
    else $error("reserved flag bit set");
  // Zero flag follows a word result
  zero_flag_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    res_valid && !res_byte && !flags_load
    |=> processor_status_word[EUFLG_B_ZF] == ($past(res_value) == 16'h0000))
    else $error("zero flag wrong");
  // Parity flag follows low byte
  parity_flag_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    res_valid && !flags_load |=> processor_status_word[EUFLG_B_PF] == ~^$past(res_value[7:0]))
    else $error("parity flag wrong");
  // Sign flag follows top result bit
  sign_flag_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    res_valid && !res_byte && !flags_load
    |=> processor_status_word[EUFLG_B_SF] == $past(res_value[15]))
    else $error("sign flag wrong");
  // Interrupt acceptance is exactly a request gated by the enable flag
  irq_gate_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    ##1 irq_accept == ($past(processor_status_word[EUFLG_B_IF]) && $past(irq_request)))
    else $error("irq acceptance wrong");
  // Fetch address is code base times sixteen plus pointer
  fetch_addr_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    ##1 fetch_addr == 20'({$past(code_segment_base), 4'h0}
                          + {4'h0, $past(fetch_offset_pointer)}))
    else $error("fetch address wrong");
  // Direction set instruction
  dir_set_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    set_direction_instr && !flags_load ##1 1'b1 |=> string_step_up)
    else $error("direction not set");
  // Carry flag follows result carry
  carry_flag_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    res_valid && !flags_load |=> processor_status_word[EUFLG_B_CF] == $past(res_carry))
    else $error("carry flag wrong");
  // A general register read waits one extra cycle for the memory
  gpr_read_wait_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    bus_state == EUFLG_BUS_IDLE && gpr_rd_hit |=> avs_waitrequest ##1 !avs_waitrequest)
    else $error("register read answered early");
  // The fetch pointer slot never shows the pointer
  ip_hidden_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    bus_state == EUFLG_BUS_IDLE && avs_read && avs_address == 6'(EUFLG_IDX_IPR)
    |=> avs_readdata == 32'h0000_0000)
    else $error("fetch pointer readable");
endmodule

// file: tb.sv
/*
  Self-checking bench for the execution unit state block.
  Assumes the design package and the bus interface stand-in model.
*/
`timescale 1ns/1ps
module tb;
  import euflg_pkg::*;
  typedef struct packed {
    logic byt; logic [15:0] val; logic [2:0] cao; logic [15:0] psw;
  } euflg_row_t;
  logic clock, rst_n, avs_read, avs_write, avs_waitrequest, res_valid, res_byte;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic [15:0] res_value, flags_value, ip_value, agen_offset, io_port_addr, exp_ip;
  logic res_carry, res_aux, res_ovf, instr_done, flags_load, flags_popped, ip_load;
  logic set_direction_instr, clear_direction_instr, set_int_enable_instr;
  logic clear_int_enable_instr, ip_fetch_step, irq_request, string_step_up;
  logic irq_accept, trace_trap, biu_en, biu_slow;
  logic [1:0] ip_step, agen_seg;
  logic [19:0] phys_addr, fetch_addr, pa;
  logic [4:0] shift_count;
  logic [7:0] n_steps;
  euflg_row_t rows [5];
  logic [3:0] seg_idx [4] = '{EUFLG_IDX_ESB, EUFLG_IDX_CSB, EUFLG_IDX_SSB, EUFLG_IDX_DSB};
  logic [15:0] rst_tab [6] = '{16'h0000, 16'hffff, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  int n_mismatch = 0;
  int num_checks = 0;

  euflg_top u_dut (.clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .res_valid, .res_byte, .res_value,
    .res_carry, .res_aux, .res_ovf, .instr_done, .flags_load, .flags_value, .flags_popped,
    .set_direction_instr, .clear_direction_instr, .set_int_enable_instr,
    .clear_int_enable_instr, .ip_load, .ip_value, .ip_fetch_step, .ip_step, .agen_seg,
    .agen_offset, .irq_request, .phys_addr, .fetch_addr, .shift_count, .io_port_addr,
    .string_step_up, .irq_accept, .trace_trap);
  euflg_biu_model u_biu (.clock, .rst_n, .enable(biu_en), .slow(biu_slow), .ip_fetch_step,
    .ip_step, .n_steps);

  // 50 MHz clock
  always begin
    #10 clock = ~clock;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // One Avalon transfer; the request holds until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d,
                     input logic [3:0] be, output logic [31:0] rq);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rq = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // A slave that never answers ends the run
    if (avs_waitrequest !== 1'b0) begin
      n_mismatch++;
      final_report();
    end
  endtask

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable, res_valid} = '0;
    {res_byte, res_value, res_carry, res_aux, res_ovf, instr_done, flags_load} = '0;
    {flags_value, flags_popped, set_direction_instr, clear_direction_instr} = '0;
    {set_int_enable_instr, clear_int_enable_instr, ip_load, ip_value} = '0;
    {agen_seg, agen_offset, irq_request, biu_en, biu_slow} = '0;
    // Result rows: byte mode, value, carry/aux/overflow, expected flags word
    rows[0] = {1'b0, 16'h0000, 3'b000, 16'h0044};
    rows[1] = {1'b0, 16'h8001, 3'b101, 16'h0881};
    rows[2] = {1'b0, 16'h0003, 3'b010, 16'h0014};
    rows[3] = {1'b1, 16'h1280, 3'b000, 16'h0080};
    rows[4] = {1'b1, 16'hff00, 3'b100, 16'h0045};
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    tick(4);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, 6'(i), 16'h0000, 4'h3, q);
      chk(q, {16'h0000, rst_tab[i]});
    end
    chk(fetch_addr, 20'hffff0);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      res_valid <= 1'b1;
      res_byte <= rows[i].byt;
      res_value <= rows[i].val;
      {res_carry, res_aux, res_ovf} <= rows[i].cao;
      @(posedge clock);
      res_valid <= 1'b0;
      bus(1'b0, 6'h00, 16'h0000, 4'h3, q);
      chk(q, {16'h0000, rows[i].psw});
    end
    bus(1'b1, 6'h00, 16'hffff, 4'h3, q);
    bus(1'b0, 6'h00, 16'h0000, 4'h3, q);
    chk(q, 32'h00000fd5);
    bus(1'b1, 6'h00, 16'h0000, 4'h3, q);
    $display("test flags done");
    // Set and clear direction and interrupt enable with a request pending
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      set_direction_instr <= (k == 0);
      set_int_enable_instr <= (k == 0);
      clear_direction_instr <= (k == 1);
      clear_int_enable_instr <= (k == 1);
      irq_request <= 1'b1;
      @(posedge clock);
      {set_direction_instr, set_int_enable_instr} <= 2'b00;
      {clear_direction_instr, clear_int_enable_instr} <= 2'b00;
      tick(3);
      chk(string_step_up, k == 0);
      chk(irq_accept, k == 0);
      bus(1'b0, 6'h00, 16'h0000, 4'h3, q);
      chk(q, (k == 0) ? 32'h00000600 : 32'h0);
    end
    $display("test direction and enable done");
    // Trace set by a flag pop: the pop itself traps not, the next one does
    @(posedge clock);
    flags_load <= 1'b1;
    flags_value <= 16'h0100;
    @(posedge clock);
    flags_load <= 1'b0;
    instr_done <= 1'b1;
    flags_popped <= 1'b1;
    @(posedge clock);
    flags_popped <= 1'b0;
    #1 chk(trace_trap, 1'b0);
    @(posedge clock);
    instr_done <= 1'b0;
    #1 chk(trace_trap, 1'b1);
    tick(1);
    chk(trace_trap, 1'b0);
    bus(1'b1, 6'h00, 16'h0000, 4'h3, q);
    $display("test trace done");
    @(posedge clock);
    ip_load <= 1'b1;
    ip_value <= 16'h0010;
    @(posedge clock);
    ip_load <= 1'b0;
    tick(3);
    chk(fetch_addr, 20'h00000);
    bus(1'b1, {2'b00, EUFLG_IDX_IPR}, 16'haaaa, 4'h3, q);
    bus(1'b0, {2'b00, EUFLG_IDX_IPR}, 16'h0000, 4'h3, q);
    chk(q, 32'h0);
    chk(fetch_addr, 20'h00000);
    // Bus unit steps the pointer, first promptly then with gaps
    @(posedge clock);
    biu_en <= 1'b1;
    repeat (5) @(posedge clock);
    biu_slow <= 1'b1;
    repeat (12) @(posedge clock);
    biu_en <= 1'b0;
    tick(4);
    exp_ip = 16'h0010 + {7'h00, n_steps, 1'b0};
    bus(1'b0, {2'b00, EUFLG_IDX_IPR}, 16'h0000, 4'h3, q);
    chk(q, 32'h0);
    chk(fetch_addr, 20'(20'hffff0 + {4'h0, exp_ip}));
    $display("test fetch pointer done");
    bus(1'b1, 6'h09, 16'h00ff, 4'h1, q);
    bus(1'b1, 6'h09, 16'h1234, 4'h2, q);
    bus(1'b0, 6'h09, 16'h0000, 4'h3, q);
    chk(q, 32'h000012ff);
    chk(shift_count, 5'h1f);
    bus(1'b1, 6'h0a, 16'hbeef, 4'h3, q);
    tick(2);
    chk(io_port_addr, 16'hbeef);
    bus(1'b1, 6'h0f, 16'h5a5a, 4'h3, q);
    bus(1'b0, 6'h0f, 16'h0000, 4'h3, q);
    chk(q, 32'h00005a5a);
    bus(1'b1, 6'h10, 16'h1234, 4'h3, q);
    bus(1'b0, 6'h10, 16'h0000, 4'h3, q);
    chk(q, 32'h0);
    bus(1'b1, 6'h18, 16'hdead, 4'h3, q);
    bus(1'b0, 6'h08, 16'h0000, 4'h3, q);
    chk(q, 32'h0);
    $display("test general registers done");
    // Bases near the top so the offset carries past bit 19
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, {2'b00, seg_idx[i]}, 16'hfff0 + 16'(i), 4'h3, q);
      bus(1'b0, {2'b00, seg_idx[i]}, 16'h0000, 4'h3, q);
      chk(q, {16'h0000, 16'hfff0 + 16'(i)});
      @(posedge clock);
      agen_seg <= 2'(i);
      agen_offset <= 16'h0200;
      tick(3);
      pa = {16'hfff0 + 16'(i), 4'h0} + 20'h00200;
      chk(phys_addr, pa);
    end
    $display("test address generation done");
    // Reset in mid-run: the changed bases and pointer return to reset values
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    tick(4);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, 6'(i), 16'h0000, 4'h3, q);
      chk(q, {16'h0000, rst_tab[i]});
    end
    chk(fetch_addr, 20'hffff0);
    $display("test mid-run reset done");
    final_report();
  end
endmodule
